// File: sram_host_pkg.sv
// package: pin widths, timing figures and cycle rounding helpers for the sram host controller
package sram_host_pkg;

  // ************************************************************
  // widths and clock
  // ************************************************************
  localparam int ADDR_W          = 13;
  localparam int DATA_W          = 8;
  localparam int CNT_W           = 4;
  localparam int SYNC_DEPTH      = 3;
  localparam int CLOCK_PERIOD_NS = 50;   // 20 mhz

  // ************************************************************
  // timing figures in ns, faster grade then slower grade
  // ************************************************************
  localparam int WRITE_PULSE_WIDTH_FAST_NS    = 55;
  localparam int WRITE_PULSE_WIDTH_SLOW_NS    = 60;
  localparam int SELECT_TO_WRITE_END_FAST_NS  = 75;
  localparam int SELECT_TO_WRITE_END_SLOW_NS  = 80;
  localparam int DATA_OVERLAP_TIME_NS         = 40;
  localparam int ADDRESS_LEAD_TIME_NS         = 0;
  localparam int WRITE_RECOVERY_TIME_NS       = 0;
  localparam int STROBE_TO_FLOAT_FAST_NS      = 30;
  localparam int STROBE_TO_FLOAT_SLOW_NS      = 35;
  localparam int READ_CYCLE_TIME_FAST_NS      = 85;
  localparam int READ_CYCLE_TIME_SLOW_NS      = 100;
  localparam int DESELECT_TO_RETENTION_NS     = 0;

  // least time rounded up to whole cycles, never below one
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ************************************************************
  // controller states, gray along the write path
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE        = 3'h0,
    ST_WR_SETUP    = 3'h1,
    ST_WR_PULSE    = 3'h3,
    ST_WR_END      = 3'h2,
    ST_RD_ACCESS   = 3'h6,
    ST_RD_SAMPLE   = 3'h7,
    ST_RET_HOLD    = 3'h5,
    ST_RET_RECOVER = 3'h4
  } host_state_t;

endpackage

// File: pin_sync.sv
// module: three-stage synchroniser for pin inputs with agreement filter
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] first_reg;
  logic [WIDTH-1:0] second_reg;
  logic [WIDTH-1:0] third_reg;

  // first stage only feeds the second, so metastability never reaches logic
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      first_reg  <= '0;
      second_reg <= '0;
      third_reg  <= '0;
    end else begin
      first_reg  <= i_pin;
      second_reg <= first_reg;
      third_reg  <= second_reg;
    end
  end

  // a bit changes only once the second and third stages agree
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (second_reg[i] == third_reg[i]) begin
          o_level[i] <= third_reg[i];
        end
      end
    end
  end

endmodule

// File: sram_host.sv
// module: host controller driving an asynchronous 8k x 8 static ram over its pins
//
// Behaviour
// RQ1: store only with both selects and strobe active
// RQ2: window opens at last asserting edge
// RQ3: window closes at first deasserting edge
// RQ4: host keeps write window open long enough
// RQ5: selects lead window close by enough time
// RQ6: address valid no later than window opening
// RQ7: address held past window close
// RQ8: write data valid before window closes
// RQ9: never drive bus while memory drives
// RQ10: gate-low write pulse covers float plus overlap
// RQ11: memory floats outputs after strobe falls
// RQ12: outputs stay off if select follows strobe
// RQ13: returned outputs first show written polarity
// RQ14: later outputs show new address contents
// RQ15: outputs return no sooner after window close
// RQ16: read address valid before selects assert
// RQ17: secondary select low gates memory inputs
// RQ18: hold secondary select firm during retention
// RQ19: deselect before supply drops into retention
// RQ20: wait read cycle after supply restored
// RQ21: memory drives only when selected and gated
// RQ22: address stable while write window open
module sram_host
#(
  parameter bit SLOW_GRADE = 1'b1
) (
  input  wire logic                              i_clock,
  input  wire logic                              i_resetn,
  input  wire logic                              i_req,
  input  wire logic                              i_write,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [sram_host_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                              i_retention_req,
  output logic                                   o_ready,
  output logic                                   o_rvalid,
  output logic      [sram_host_pkg::DATA_W-1:0] o_rdata,
  output logic                                   o_retention_ready,
  output logic                                   o_primary_select_n,
  output logic                                   o_secondary_select,
  output logic                                   o_write_strobe_n,
  output logic                                   o_output_gate_n,
  output logic      [sram_host_pkg::ADDR_W-1:0] o_word_address,
  output logic      [sram_host_pkg::DATA_W-1:0] o_data_out,
  output logic                                   o_data_oe,
  input  wire logic [sram_host_pkg::DATA_W-1:0] i_data_in
);

  import sram_host_pkg::*;

  // ************************************************************
  // cycle counts
  // ************************************************************
  localparam int WP_NS = SLOW_GRADE ? WRITE_PULSE_WIDTH_SLOW_NS : WRITE_PULSE_WIDTH_FAST_NS;
  localparam int CW_NS = SLOW_GRADE ? SELECT_TO_WRITE_END_SLOW_NS : SELECT_TO_WRITE_END_FAST_NS;
  localparam int RC_NS = SLOW_GRADE ? READ_CYCLE_TIME_SLOW_NS : READ_CYCLE_TIME_FAST_NS;
  // selects lead the strobe by one setup cycle, so that cycle counts toward the select figure
  localparam int PULSE_CYC   = max2(max2(ceil_cycles(WP_NS), ceil_cycles(DATA_OVERLAP_TIME_NS)),
                                    max2(ceil_cycles(CW_NS) - 1, 1));
  localparam int READ_CYC    = ceil_cycles(RC_NS);
  localparam int SAMPLE_CYC  = READ_CYC + SYNC_DEPTH;
  localparam int RECOVER_CYC = ceil_cycles(RC_NS);
  localparam logic [CNT_W-1:0] PULSE_LAST   = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LAST  = CNT_W'(SAMPLE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVER_LAST = CNT_W'(RECOVER_CYC - 1);

  host_state_t               state_reg;
  host_state_t               state_next;
  logic [CNT_W-1:0]          cnt_reg;
  logic [DATA_W-1:0]         wdata_reg;
  logic [DATA_W-1:0]         data_level;

  // ************************************************************
  // read data synchroniser
  // ************************************************************
  pin_sync #(
    .WIDTH (DATA_W)
  ) u_data_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    (i_data_in),
    .o_level  (data_level)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  // next state; retention wins over a new access taken in the same cycle
  // nothing is taken before ready is shown, so a request held across reset release waits
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (o_ready && i_retention_req) begin
          state_next = ST_RET_HOLD;                                  // [RQ19]
        end else if (o_ready && i_req && i_write) begin
          state_next = ST_WR_SETUP;
        end else if (o_ready && i_req) begin
          state_next = ST_RD_ACCESS;
        end
      end
      ST_WR_SETUP:    state_next = ST_WR_PULSE;
      ST_WR_PULSE:    state_next = (cnt_reg == PULSE_LAST) ? ST_WR_END : ST_WR_PULSE;   // [RQ4] [RQ5]
      ST_WR_END:      state_next = ST_IDLE;
      ST_RD_ACCESS:   state_next = (cnt_reg == SAMPLE_LAST) ? ST_RD_SAMPLE : ST_RD_ACCESS;
      ST_RD_SAMPLE:   state_next = ST_IDLE;
      ST_RET_HOLD:    state_next = i_retention_req ? ST_RET_HOLD : ST_RET_RECOVER;
      ST_RET_RECOVER: state_next = (cnt_reg == RECOVER_LAST) ? ST_IDLE : ST_RET_RECOVER; // [RQ20]
      default:        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // phase counter restarts on every state change
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  // address and write data latched when an access is taken, held to the cycle end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_word_address <= '0;
      wdata_reg      <= '0;
    end else if (state_reg == ST_IDLE && state_next != ST_IDLE && state_next != ST_RET_HOLD) begin
      o_word_address <= i_addr;                                      // [RQ6] [RQ16] [RQ7] [RQ22]
      wdata_reg      <= i_wdata;
    end
  end

  // selects assert on the edge that latches the address; a zero lead is allowed, a late address is not
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_primary_select_n <= 1'b1;
      o_secondary_select <= 1'b0;
    end else begin
      o_primary_select_n <= !(state_next inside {ST_WR_SETUP, ST_WR_PULSE, ST_RD_ACCESS, ST_RD_SAMPLE});
      // parked firmly low during retention so the memory gates its other inputs
      o_secondary_select <= state_next inside {ST_WR_SETUP, ST_WR_PULSE, ST_RD_ACCESS, ST_RD_SAMPLE}; // [RQ18]
    end
  end

  // strobe is the last to assert and releases on the same edge as the selects, so it frames the window
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_write_strobe_n <= 1'b1;
    end else begin
      o_write_strobe_n <= (state_next != ST_WR_PULSE);               // [RQ2] [RQ3] [RQ1]
    end
  end

  // gate stays high through writes, which sidesteps the gate-low pulse penalty
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_output_gate_n <= 1'b1;
    end else begin
      o_output_gate_n <= !(state_next inside {ST_RD_ACCESS, ST_RD_SAMPLE}); // [RQ10]
    end
  end

  // bus is driven only from the pulse on; the setup cycle gives the memory time to float
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data_oe  <= 1'b0;
      o_data_out <= '0;
    end else begin
      o_data_oe  <= state_next inside {ST_WR_PULSE, ST_WR_END};      // [RQ9] [RQ8]
      o_data_out <= wdata_reg;
    end
  end

  // ************************************************************
  // user side
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ready           <= 1'b0;
      o_rvalid          <= 1'b0;
      o_rdata           <= '0;
      o_retention_ready <= 1'b0;
    end else begin
      o_ready           <= (state_next == ST_IDLE);
      o_rvalid          <= (state_reg == ST_RD_SAMPLE);
      o_retention_ready <= (state_next == ST_RET_HOLD);             // [RQ19]
      if (state_reg == ST_RD_SAMPLE) begin
        o_rdata <= data_level;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  property p_strobe_selected;
    !o_write_strobe_n |-> !o_primary_select_n && o_secondary_select;
  endproperty
  a_strobe_selected: assert property (p_strobe_selected) else $error("strobe low while deselected"); // [RQ1]

  property p_window_width;
    $fell(o_write_strobe_n) |-> (!o_write_strobe_n)[*2] ##1 o_write_strobe_n;
  endproperty
  a_window_width: assert property (p_window_width) else $error("write window width wrong"); // [RQ4]

  property p_select_lead;
    $fell(o_write_strobe_n) |-> $past(!o_primary_select_n) && $past(o_secondary_select);
  endproperty
  a_select_lead: assert property (p_select_lead) else $error("selects not ahead of window"); // [RQ5]

  property p_addr_lead;
    $fell(o_write_strobe_n) |-> $stable(o_word_address);
  endproperty
  a_addr_lead: assert property (p_addr_lead) else $error("address moved at window open"); // [RQ6]

  property p_addr_hold;
    !o_write_strobe_n |=> $stable(o_word_address);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in or after window"); // [RQ22]

  property p_data_overlap;
    $rose(o_write_strobe_n) |-> $past(o_data_oe) && $past(o_data_oe, 2) && o_data_oe;
  endproperty
  a_data_overlap: assert property (p_data_overlap) else $error("data not held across window"); // [RQ8]

  property p_no_contention;
    o_data_oe |-> o_output_gate_n && $past(o_output_gate_n) && $past(o_output_gate_n, 2);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus driven while memory may drive"); // [RQ9]

  property p_gate_high_in_write;
    !o_write_strobe_n |-> o_output_gate_n;
  endproperty
  a_gate_high_in_write: assert property (p_gate_high_in_write) else $error("gate low during write"); // [RQ10]

  property p_read_addr;
    $past(!o_primary_select_n) && !o_primary_select_n |-> $stable(o_word_address);
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address changed at select"); // [RQ16]

  property p_retention_park;
    o_retention_ready |-> o_primary_select_n && !o_secondary_select && $past(o_primary_select_n);
  endproperty
  a_retention_park: assert property (p_retention_park) else $error("not deselected in retention"); // [RQ18]

  property p_recovery;
    $fell(o_retention_ready) |-> (o_primary_select_n && !o_ready)[*2];
  endproperty
  a_recovery: assert property (p_recovery) else $error("access too soon after retention"); // [RQ20]

  c_write:     cover property ($fell(o_write_strobe_n) ##[1:4] $rose(o_write_strobe_n));
  c_read:      cover property ($rose(o_rvalid));
  c_retention: cover property ($rose(o_retention_ready) ##[1:20] $fell(o_retention_ready));
  c_wr_rd:     cover property ($rose(o_write_strobe_n) ##[1:6] $fell(o_output_gate_n));

endmodule

// File: sram_model.sv
// partner model: behavioural 8k x 8 static ram that also watches the host's pin timing
module sram_model #(
  parameter int WP_NS = 60,
  parameter int CW_NS = 80,
  parameter int DW_NS = 40,
  parameter int RC_NS = 100
) (
  input  wire logic [sram_host_pkg::ADDR_W-1:0] i_word_address,
  input  wire logic                              i_primary_select_n,
  input  wire logic                              i_secondary_select,
  input  wire logic                              i_write_strobe_n,
  input  wire logic                              i_output_gate_n,
  input  wire logic [sram_host_pkg::DATA_W-1:0] i_host_data,
  input  wire logic                              i_host_oe,
  input  wire logic                              i_supply_on,
  output logic      [sram_host_pkg::DATA_W-1:0] o_shared_data_bus,
  output int                                     o_violations,
  output int                                     o_writes
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_host_pkg::*;
  logic [DATA_W-1:0] mem [0:8191];
  logic [DATA_W-1:0] last;
  logic              sel_pins, sel, win, drive;
  realtime           t_sel, t_open, t_data, t_addr, t_up;

  // ********************
  // array behaviour
  // ********************
  initial begin
    o_violations = 0;
    o_writes = 0;
    last = '0;
    t_up = -1000.0;
  end
  // secondary select low gates every other input off, so floating pins do nothing
  assign sel_pins = !i_primary_select_n && i_secondary_select;
  assign sel      = sel_pins && i_supply_on;
  assign win      = sel && !i_write_strobe_n;
  // same delay both ways: floats well inside the limit, never returns early
  assign #10 drive = sel && i_write_strobe_n && !i_output_gate_n;
  // a released bus shows the inverse of the last driven value, never a stale copy
  always @* begin
    if (i_host_oe) last = i_host_data;
    else if (drive) last = mem[i_word_address];
    o_shared_data_bus = (i_host_oe || drive) ? last : ~last;
  end
  // store at the first closing edge and judge the window just closed
  // the unknown-to-low settle at time zero is not a closing edge and stores nothing
  always @(negedge win) begin
    if ($realtime > 0) begin
      mem[i_word_address] = o_shared_data_bus;
      o_writes++;
      if ($realtime - t_open < WP_NS) o_violations++;
      if ($realtime - t_sel < CW_NS) o_violations++;
      if ($realtime - t_data < DW_NS || !i_host_oe) o_violations++;
    end
  end

  // ********************
  // host timing watch
  // ********************
  always @(posedge sel_pins) t_sel = $realtime;
  always @(posedge win) t_open = $realtime;
  always @(i_host_data or i_host_oe) t_data = $realtime;
  always @(i_word_address) t_addr = $realtime;
  always @(posedge i_supply_on) t_up = $realtime;
  // address settles no later than the selects and holds until they release
  always @(negedge sel_pins) if (t_addr > t_sel) o_violations++;
  // contention: host drives while the array's outputs are on
  always @(i_host_oe or sel or drive or i_write_strobe_n or i_output_gate_n) begin
    if (i_host_oe && (drive || sel && i_write_strobe_n && !i_output_gate_n)) o_violations++;
  end
  always @(negedge i_supply_on) if (i_secondary_select) o_violations++;
  always @(i_secondary_select) if (!i_supply_on) o_violations++;
  always @(posedge sel_pins) if ($realtime - t_up < RC_NS) o_violations++;
endmodule

// File: tb_top.sv
// testbench: sram host controller driving the behavioural ram model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_host_pkg::*;
  logic              i_clock, i_resetn, i_req, i_write, i_retention_req, supply_on;
  logic              o_ready, o_rvalid, o_retention_ready, o_data_oe;
  logic              o_primary_select_n, o_secondary_select, o_write_strobe_n, o_output_gate_n;
  logic [ADDR_W-1:0] i_addr, o_word_address;
  logic [DATA_W-1:0] i_wdata, o_rdata, o_data_out, bus;
  int                n_errors, compares, violations, writes;

  sram_host dut (.i_clock, .i_resetn, .i_req, .i_write, .i_addr, .i_wdata, .i_retention_req,
    .o_ready, .o_rvalid, .o_rdata, .o_retention_ready, .o_primary_select_n, .o_secondary_select,
    .o_write_strobe_n, .o_output_gate_n, .o_word_address, .o_data_out, .o_data_oe, .i_data_in(bus));
  sram_model ram (.i_word_address(o_word_address), .i_primary_select_n(o_primary_select_n),
    .i_secondary_select(o_secondary_select), .i_write_strobe_n(o_write_strobe_n),
    .i_output_gate_n(o_output_gate_n), .i_host_data(o_data_out), .i_host_oe(o_data_oe),
    .i_supply_on(supply_on), .o_shared_data_bus(bus), .o_violations(violations), .o_writes(writes));

  // ********************
  // shared tasks
  // ********************
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    check("timing violations", violations, 0);
    $display("checks %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait on ready (0), read valid (1) or retention ready (2), sampled at the edge
  task automatic wait_sig(input int sel);
    int   n;
    logic v;
    n = 0;
    v = 1'b0;
    while (v !== 1'b1) begin
      @(posedge i_clock);
      v = (sel == 0) ? o_ready : (sel == 1) ? o_rvalid : o_retention_ready;
      n++;
      if (n > 50) begin
        n_errors++;
        $display("wrong value wait %0d: expected 1, seen 0", sel);
        end_of_test();
      end
    end
  endtask
  // one access; inputs are scrambled while busy, as the host must not use them then
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    i_req <= 1'b1;
    i_write <= wr;
    i_addr <= a;
    i_wdata <= d;
    wait_sig(0);
    i_req <= 1'b0;
    i_addr <= ~a;
    i_wdata <= ~d;
    wait_sig(wr ? 0 : 1);
    q = o_rdata;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic test_write_read();
    logic [ADDR_W-1:0] a [4];
    logic [DATA_W-1:0] d [4];
    logic [DATA_W-1:0] q;
    a = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
    d = '{8'h00, 8'hff, 8'ha5, 8'h5a};
    for (int i = 0; i < 4; i++) access(1'b1, a[i], d[i], q);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, a[i], 8'h00, q);
      check("read back", q, d[i]);
    end
    check("stored writes", writes, 4);
    $display("test write_read done");
  endtask
  task automatic test_overwrite();
    logic [DATA_W-1:0] q;
    access(1'b1, 13'h0010, 8'h3c, q);
    access(1'b1, 13'h0011, 8'hc3, q);
    access(1'b1, 13'h0010, 8'h81, q);
    access(1'b0, 13'h0011, 8'h00, q);
    check("neighbour kept", q, 8'hc3);
    access(1'b0, 13'h0010, 8'h00, q);
    check("overwritten", q, 8'h81);
    $display("test overwrite done");
  endtask
  task automatic test_retention();
    logic [DATA_W-1:0] q;
    i_retention_req <= 1'b1;
    i_req <= 1'b1;
    i_write <= 1'b1;
    wait_sig(2);
    check("selects in retention", {o_primary_select_n, o_secondary_select}, 2'b10);
    supply_on <= 1'b0;
    repeat (6) @(posedge i_clock);
    check("ready in retention", o_ready, 1'b0);
    supply_on <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_retention_req <= 1'b0;
    i_req <= 1'b0;
    wait_sig(0);
    check("writes in retention", writes, 7);
    access(1'b0, 13'h1fff, 8'h00, q);
    check("kept through retention", q, 8'hff);
    $display("test retention done");
  endtask

  initial begin
    n_errors = 0;
    compares = 0;
    i_resetn = 1'b0;
    i_req = 1'b0;
    i_write = 1'b0;
    i_retention_req = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    supply_on = 1'b1;
    repeat (3) @(posedge i_clock);
    check("pins in reset", {o_primary_select_n, o_secondary_select, o_write_strobe_n,
          o_output_gate_n, o_data_oe, o_ready}, 6'h2c);
    $display("test reset done");
    i_resetn <= 1'b1;
    test_write_read();
    test_overwrite();
    test_retention();
    end_of_test();
  end
endmodule
